// >>> inc/hpsm_regs.svh
// Register offsets, field positions, reset values and address constants
//
// Functional notes
// - Direct mode: aux pin drives aux supply, main-on pin drives main supply, per slot.
// - Without bus, power-good and fault pins are the only direct-mode status.
// - Bus reads of status and inputs are answered in direct mode too.
// - Any write to a slot control register enters bus mode until power cycle.
// - Function register writes are accepted in direct mode without leaving it.
// - Status fault bit mirrors slot fault pin; inactive under bus control.
// - All registers load defaults at power-up and when enabled.
// - Bytes go most significant bit first, eight bits, then acknowledge.
// - Device address is 1000 followed by three address-select pins.
// - Eighth address bit carries read/write direction.
// - Link clock comes from host, 10 kHz to 400 kHz, all tolerated.
// - Registers show whether supplies were enabled by pins or by bus.
// - Sticky fault bits stay set after the fault goes away.
// - After host writes 1, bit clears on next read if fault gone.
// - Echo reset covers slot status bits 0, 2, 4 and common bits 1, 2.
// - Commands 02h to 07h decode registers; 00h and 01h unassigned.
// - Reserved bits are read-only and read zero.
// - Control bits: 0 aux enable, 1 main enable, 2 force inhibit.
// - Function register resets to 0Dh; others reset to 00h.
// - Interrupt mask bit 1 disables fault interrupt in bus mode only, 0 enables; default enabled.
`ifndef HPSM_REGS_SVH
`define HPSM_REGS_SVH
`define HPSM_OFS_CTRL_A     8'h02
`define HPSM_OFS_CTRL_B     8'h03
`define HPSM_OFS_STAT_A     8'h04
`define HPSM_OFS_STAT_B     8'h05
`define HPSM_OFS_COMMON     8'h06
`define HPSM_OFS_FUNC       8'h07
`define HPSM_RST_CTRL       8'h00
`define HPSM_RST_STAT       8'h00
`define HPSM_RST_COMMON     8'h00
`define HPSM_RST_FUNC       8'h0D
`define HPSM_ADDR_HI        4'h8
`define HPSM_CTRL_WMASK     8'h07
`define HPSM_STAT_STICKY    8'h15
`define HPSM_COMMON_STICKY  8'h06
`define HPSM_COMMON_WMASK   8'h0E
`define HPSM_FUNC_WMASK     8'hCC
`define HPSM_FUNC_ROBIT     8'h01
`define HPSM_BIT_AUXEN      0
`define HPSM_BIT_MAINEN     1
`define HPSM_BIT_INHIB      2
`define HPSM_BIT_MASK       3
`endif

// >>> inc/hpsm_pkg.sv
// Types for the hot plug bus-mode register block
package hpsm_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_WDATA,
		ST_RDATA,
		ST_WAIT
	} hpsm_link_st_t;

	typedef struct packed {
		logic aux_fault;
		logic main3_fault;
		logic main12_fault;
		logic aux_pgood;
		logic main_pgood;
	} hpsm_slot_t;

	typedef struct packed {
		logic [3:0] gpi;
		logic       uv_fault;
		logic       ot_fault;
		logic [1:0] pwroff;
	} hpsm_common_t;

	typedef struct packed {
		logic       valid;
		logic       rd;
		logic [7:0] cmd;
		logic [7:0] data;
	} hpsm_xfer_t;
endpackage

// >>> src/hpsm_regs_top.sv
// Bus target, register map and direct/bus control mode for two hot plug slots
`timescale 1ns/10ps
`default_nettype none
`include "hpsm_regs.svh"
module hpsm_regs_top (
	input  wire logic                  clk_in,
	input  wire logic                  srst_in,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe_n_out,
	input  wire logic [2:0]            address_select_pins_in,
	input  wire logic [1:0]            aux_enable_pin_in,
	input  wire logic [1:0]            main_on_pin_in,
	input  wire logic [1:0]            slot_fault_pin_in,
	input  wire hpsm_pkg::hpsm_slot_t  slot_a_in,
	input  wire hpsm_pkg::hpsm_slot_t  slot_b_in,
	input  wire hpsm_pkg::hpsm_common_t common_in,
	output logic [1:0]                 aux_supply_out,
	output logic [1:0]                 main_supply_out,
	output logic [1:0]                 force_pin_inhibit_out,
	output logic                       bus_mode_out,
	output logic                       irq_n_out,
	output logic [7:0]                 func_reg_out
);
	import hpsm_pkg::*;

	// ****************************************
	// Link and core domain state
	// ****************************************
	typedef struct packed {
		hpsm_link_st_t st;
		logic [3:0]    bitcnt;
		logic [7:0]    shreg;
		logic          rd;
		logic [7:0]    cmd;
		logic          ack;
		logic          drive0;
		logic          tgl;
		hpsm_xfer_t    xf;
		logic [7:0]    rsync2;
	} hpsm_link_s_t;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] tgl_s;
		logic [2:0] asel1;
		logic [2:0] asel2;
		logic [1:0] aux1;
		logic [1:0] aux2;
		logic [1:0] main1;
		logic [1:0] main2;
		logic [1:0] flt1;
		logic [1:0] flt2;
		logic       bus_mode;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] stat_a;
		logic [7:0] stat_b;
		logic [7:0] common;
		logic [7:0] func;
		logic [7:0] echo_a;
		logic [7:0] echo_b;
		logic [7:0] echo_c;
		logic [7:0] rdata;
		logic [1:0] aux_o;
		logic [1:0] main_o;
		logic       irq_n;
	} hpsm_core_s_t;

	hpsm_link_s_t lnk_ff, nxt_lnk;
	hpsm_core_s_t core_ff, nxt_core;

	function automatic logic is_reg(input logic [7:0] c);
		is_reg = (c >= `HPSM_OFS_CTRL_A) && (c <= `HPSM_OFS_FUNC);
	endfunction

	// Sticky bit: set by fault, cleared on read once echoed and fault gone
	function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] live,
		input logic [7:0] echo, input logic [7:0] msk, input logic rd_now);
		logic [7:0] clr;
		clr = (rd_now ? (echo & ~live) : 8'h00) & msk;
		sticky = ((cur & ~clr) | live) & msk;
	endfunction

	// ****************************************
	// Link logic on the host clock
	// ****************************************
	// Samples data on the rising clock edge, changes its drive on falling edges.
	// Start and stop are seen through the core domain, which sees both lines.
	logic start_seen_ff, stop_seen_ff;
	logic [2:0] start_l, stop_l;

	always_comb begin
		nxt_lnk = lnk_ff;
		// Shift even while idle: the start reaches here only on the third edge
		if (lnk_ff.bitcnt < 4'h8) begin
			nxt_lnk.shreg = {lnk_ff.shreg[6:0], sda_in};
		end
		if (start_l[2] != start_l[1]) begin
			nxt_lnk.st = ST_ADDR;
			nxt_lnk.bitcnt = 4'h3;
		end else if (lnk_ff.st != ST_IDLE && lnk_ff.st != ST_WAIT) begin
			nxt_lnk.bitcnt = lnk_ff.bitcnt + 4'h1;
			if (lnk_ff.bitcnt == 4'h8) begin
				nxt_lnk.bitcnt = 4'h0;
				if (!lnk_ff.ack) begin
					nxt_lnk.st = ST_WAIT;
				end else begin
					case (lnk_ff.st)
						ST_ADDR: begin
							nxt_lnk.rd = lnk_ff.shreg[0];
							nxt_lnk.st = ST_CMD;
						end
						ST_CMD: begin
							nxt_lnk.cmd = lnk_ff.shreg;
							nxt_lnk.st = lnk_ff.rd ? ST_RDATA : ST_WDATA;
							// Word held still by the request toggle, one capture is enough
							if (lnk_ff.rd) begin
								nxt_lnk.rsync2 = core_ff.rdata;
							end
						end
						ST_WDATA: begin
							nxt_lnk.xf = '{1'b1, 1'b0, lnk_ff.cmd, lnk_ff.shreg};
							nxt_lnk.tgl = ~lnk_ff.tgl;
							nxt_lnk.st = ST_WAIT;
						end
						default: nxt_lnk.st = ST_WAIT;
					endcase
				end
			end
		end
		// Acknowledge decision taken on the eighth rising edge
		if (lnk_ff.bitcnt == 4'h7) begin
			case (lnk_ff.st)
				ST_ADDR: nxt_lnk.ack = (lnk_ff.shreg[6:0] == {`HPSM_ADDR_HI, core_ff.asel2});
				ST_CMD: begin
					nxt_lnk.ack = is_reg({lnk_ff.shreg[6:0], sda_in});
					// Read asked for one bit early so data is ready at the ack edge
					if (lnk_ff.rd && is_reg({lnk_ff.shreg[6:0], sda_in})) begin
						nxt_lnk.xf = '{1'b1, 1'b1, {lnk_ff.shreg[6:0], sda_in}, 8'h00};
						nxt_lnk.tgl = ~lnk_ff.tgl;
					end
				end
				ST_WDATA: nxt_lnk.ack = 1'b1;
				default: nxt_lnk.ack = 1'b0;
			endcase
		end
	end

	always_ff @(posedge scl_in) begin
		if (srst_in) begin
			lnk_ff <= '0;
		end else begin
			lnk_ff <= nxt_lnk;
		end
	end

	// Crossings of start/stop events into link domain (toggle, two stages)
	always_ff @(posedge scl_in) begin
		if (srst_in) begin
			start_l <= 3'h0;
			stop_l  <= 3'h0;
		end else begin
			start_l <= {start_l[1:0], start_seen_ff};
			stop_l  <= {stop_l[1:0], stop_seen_ff};
		end
	end

	// Output drive on falling edge: acknowledge slot or read data bit
	logic drv_ff;
	always_ff @(negedge scl_in) begin
		if (srst_in) begin
			drv_ff <= 1'b0;
		end else if (lnk_ff.bitcnt == 4'h8 && lnk_ff.ack) begin
			drv_ff <= 1'b1;
		end else if (lnk_ff.st == ST_RDATA && lnk_ff.bitcnt < 4'h8) begin
			drv_ff <= ~lnk_ff.rsync2[3'(4'h7 - lnk_ff.bitcnt)];
		end else begin
			drv_ff <= 1'b0;
		end
	end

	// ****************************************
	// Core logic on the system clock
	// ****************************************
	logic        tgl_seen;
	logic        sda_rise, sda_fall;
	hpsm_xfer_t  xf_c;
	hpsm_slot_t  sl_a, sl_b;
	logic        wr_ctrl;

	always_comb begin
		tgl_seen = core_ff.tgl_s[2] != core_ff.tgl_s[1];
		sda_fall = core_ff.sda_s[2] & ~core_ff.sda_s[1];
		sda_rise = ~core_ff.sda_s[2] & core_ff.sda_s[1];
		xf_c = lnk_ff.xf;
		sl_a = slot_a_in;
		sl_b = slot_b_in;
		wr_ctrl = tgl_seen && !xf_c.rd &&
			(xf_c.cmd == `HPSM_OFS_CTRL_A || xf_c.cmd == `HPSM_OFS_CTRL_B);
		nxt_core = core_ff;
		nxt_core.scl_s = {core_ff.scl_s[1:0], scl_in};
		nxt_core.sda_s = {core_ff.sda_s[1:0], sda_in};
		nxt_core.tgl_s = {core_ff.tgl_s[1:0], lnk_ff.tgl};
		nxt_core.asel1 = address_select_pins_in;
		nxt_core.asel2 = core_ff.asel1;
		nxt_core.aux1  = aux_enable_pin_in;
		nxt_core.aux2  = core_ff.aux1;
		nxt_core.main1 = main_on_pin_in;
		nxt_core.main2 = core_ff.main1;
		nxt_core.flt1  = slot_fault_pin_in;
		nxt_core.flt2  = core_ff.flt1;
		if (wr_ctrl) begin
			nxt_core.bus_mode = 1'b1;
		end
		// Sticky faults, live status and echo-reset handling
		nxt_core.stat_a = sticky(core_ff.stat_a,
			{3'b000, sl_a.aux_fault, 1'b0, sl_a.main12_fault, 1'b0, sl_a.main3_fault},
			core_ff.echo_a, `HPSM_STAT_STICKY,
			tgl_seen && xf_c.rd && xf_c.cmd == `HPSM_OFS_STAT_A);
		nxt_core.stat_b = sticky(core_ff.stat_b,
			{3'b000, sl_b.aux_fault, 1'b0, sl_b.main12_fault, 1'b0, sl_b.main3_fault},
			core_ff.echo_b, `HPSM_STAT_STICKY,
			tgl_seen && xf_c.rd && xf_c.cmd == `HPSM_OFS_STAT_B);
		// Fault pin is low when the slot is in fault
		nxt_core.stat_a[7] = !core_ff.bus_mode & ~core_ff.flt2[0];
		nxt_core.stat_b[7] = !core_ff.bus_mode & ~core_ff.flt2[1];
		nxt_core.stat_a[6] = core_ff.main_o[0];
		nxt_core.stat_a[5] = core_ff.aux_o[0];
		nxt_core.stat_b[6] = core_ff.main_o[1];
		nxt_core.stat_b[5] = core_ff.aux_o[1];
		nxt_core.common = (sticky(core_ff.common,
			{5'b00000, common_in.uv_fault, common_in.ot_fault, 1'b0},
			core_ff.echo_c, `HPSM_COMMON_STICKY,
			tgl_seen && xf_c.rd && xf_c.cmd == `HPSM_OFS_COMMON)) |
			{common_in.gpi, core_ff.common[`HPSM_BIT_MASK], 3'b000};
		nxt_core.func = (core_ff.func & ~`HPSM_FUNC_WMASK & ~8'h30) |
			{2'b00, common_in.pwroff, 4'h0} | (core_ff.func & `HPSM_FUNC_WMASK);
		nxt_core.ctrl_a[7:6] = {sl_a.aux_pgood, sl_a.main_pgood};
		nxt_core.ctrl_b[7:6] = {sl_b.aux_pgood, sl_b.main_pgood};
		if (tgl_seen && !xf_c.rd) begin
			case (xf_c.cmd)
				`HPSM_OFS_CTRL_A: nxt_core.ctrl_a[2:0] = xf_c.data[2:0];
				`HPSM_OFS_CTRL_B: nxt_core.ctrl_b[2:0] = xf_c.data[2:0];
				`HPSM_OFS_STAT_A: nxt_core.echo_a = core_ff.echo_a |
					(xf_c.data & core_ff.stat_a & `HPSM_STAT_STICKY);
				`HPSM_OFS_STAT_B: nxt_core.echo_b = core_ff.echo_b |
					(xf_c.data & core_ff.stat_b & `HPSM_STAT_STICKY);
				`HPSM_OFS_COMMON: begin
					nxt_core.echo_c = core_ff.echo_c |
						(xf_c.data & core_ff.common & `HPSM_COMMON_STICKY);
					nxt_core.common[`HPSM_BIT_MASK] = xf_c.data[`HPSM_BIT_MASK];
				end
				`HPSM_OFS_FUNC: nxt_core.func = (nxt_core.func & ~`HPSM_FUNC_WMASK) |
					(xf_c.data & `HPSM_FUNC_WMASK);
				default: ;
			endcase
		end
		// Read data loaded for the link; cleared echoes once read
		if (tgl_seen && xf_c.rd) begin
			case (xf_c.cmd)
				`HPSM_OFS_CTRL_A: nxt_core.rdata = core_ff.ctrl_a & 8'hC7;
				`HPSM_OFS_CTRL_B: nxt_core.rdata = core_ff.ctrl_b & 8'hC7;
				`HPSM_OFS_STAT_A: begin
					nxt_core.rdata = core_ff.stat_a & 8'hF5;
					nxt_core.echo_a = 8'h00;
				end
				`HPSM_OFS_STAT_B: begin
					nxt_core.rdata = core_ff.stat_b & 8'hF5;
					nxt_core.echo_b = 8'h00;
				end
				`HPSM_OFS_COMMON: begin
					nxt_core.rdata = core_ff.common & 8'hFE;
					nxt_core.echo_c = 8'h00;
				end
				`HPSM_OFS_FUNC: nxt_core.rdata = core_ff.func;
				default: nxt_core.rdata = 8'h00;
			endcase
		end
		// Supply control: pins in direct mode, bits in bus mode
		for (int s = 0; s < 2; s++) begin
			nxt_core.aux_o[s] = core_ff.bus_mode ?
				(s == 0 ? core_ff.ctrl_a[`HPSM_BIT_AUXEN] : core_ff.ctrl_b[`HPSM_BIT_AUXEN]) :
				core_ff.aux2[s];
			nxt_core.main_o[s] = core_ff.bus_mode ?
				(s == 0 ? core_ff.ctrl_a[`HPSM_BIT_MAINEN] : core_ff.ctrl_b[`HPSM_BIT_MAINEN]) :
				core_ff.main2[s];
		end
		nxt_core.irq_n = !(((|core_ff.stat_a[4:0]) || (|core_ff.stat_b[4:0]) ||
			(|core_ff.common[2:1])) &&
			!(core_ff.bus_mode && core_ff.common[`HPSM_BIT_MASK]));
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			core_ff <= '0;
			core_ff.func <= `HPSM_RST_FUNC;
		end else begin
			core_ff <= nxt_core;
		end
	end

	// Start and stop seen as data edges while clock high; toggled events
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			start_seen_ff <= 1'b0;
			stop_seen_ff  <= 1'b0;
		end else begin
			if (core_ff.scl_s[2] && core_ff.scl_s[1] && sda_fall) begin
				start_seen_ff <= ~start_seen_ff;
			end
			if (core_ff.scl_s[2] && core_ff.scl_s[1] && sda_rise) begin
				stop_seen_ff <= ~stop_seen_ff;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic [1:0] drv_s_ff;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			drv_s_ff     <= 2'b00;
			sda_oe_n_out <= 1'b1;
		end else begin
			drv_s_ff     <= {drv_s_ff[0], drv_ff};
			sda_oe_n_out <= ~drv_s_ff[1];
		end
	end

	always_ff @(posedge clk_in) begin
		sda_out               <= 1'b0;
		aux_supply_out        <= core_ff.aux_o;
		main_supply_out       <= core_ff.main_o;
		force_pin_inhibit_out <= {core_ff.ctrl_b[`HPSM_BIT_INHIB], core_ff.ctrl_a[`HPSM_BIT_INHIB]};
		bus_mode_out          <= core_ff.bus_mode;
		irq_n_out             <= srst_in ? 1'b1 : core_ff.irq_n;
		func_reg_out          <= core_ff.func;
	end
endmodule
`default_nettype wire

// >>> tb/hpsm_regs_props.sv
// Port-level checks for the hot plug register block
`timescale 1ns/10ps
`default_nettype none
module hpsm_regs_props (
	input wire logic       clk_in,
	input wire logic       srst_in,
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_n_out,
	input wire logic [1:0] aux_enable_pin_in,
	input wire logic [1:0] main_on_pin_in,
	input wire logic [1:0] aux_supply_out,
	input wire logic [1:0] main_supply_out,
	input wire logic [1:0] force_pin_inhibit_out,
	input wire logic       bus_mode_out,
	input wire logic       irq_n_out,
	input wire logic [7:0] func_reg_out
);
	// ****
	// Checks
	// ****
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	a_reset_values: assert property ($fell(srst_in) |-> func_reg_out == 8'h0D
		&& !bus_mode_out && irq_n_out && sda_oe_n_out && aux_supply_out == 2'h0)
		else $error("reset values wrong");
	a_mode_stays: assert property (bus_mode_out |=> bus_mode_out)
		else $error("bus mode left");
	a_direct_aux: assert property ((!bus_mode_out && $stable(aux_enable_pin_in)) [*6]
		|-> aux_supply_out == aux_enable_pin_in) else $error("aux supply not following pin");
	a_direct_main: assert property ((!bus_mode_out && $stable(main_on_pin_in)) [*6]
		|-> main_supply_out == main_on_pin_in) else $error("main supply not following pin");
	a_drive_low_phase: assert property ($changed(sda_oe_n_out) |-> !scl_in)
		else $error("data changed with clock high");
	a_bit_stands: assert property ($fell(sda_oe_n_out) |-> (!sda_oe_n_out) [*8])
		else $error("driven bit too short");
	a_pull_low_only: assert property (!sda_oe_n_out |-> !sda_out)
		else $error("data line driven high");
	a_inhib_bus: assert property ($rose(|force_pin_inhibit_out) |-> ##[0:2] bus_mode_out)
		else $error("inhibit set outside bus mode");
	a_func_fixed: assert property (func_reg_out[1:0] == 2'h1)
		else $error("fixed function bits wrong");
endmodule
bind hpsm_regs_top hpsm_regs_props u_props (.clk_in(clk_in), .srst_in(srst_in),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
	.aux_enable_pin_in(aux_enable_pin_in), .main_on_pin_in(main_on_pin_in),
	.aux_supply_out(aux_supply_out), .main_supply_out(main_supply_out),
	.force_pin_inhibit_out(force_pin_inhibit_out), .bus_mode_out(bus_mode_out),
	.irq_n_out(irq_n_out), .func_reg_out(func_reg_out));
`default_nettype wire

// >>> tb/hpsm_host_model.sv
// Behavioural host controller for the serial link
`timescale 1ns/10ps
`default_nettype none
module hpsm_host_model (
	output logic      scl_out,
	output logic      sda_low_out,
	input  wire logic sda_in
);
	// ****
	// Link driver
	// ****
	int half = 80;
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Lone clock edge so link state sees the reset
	task automatic pulse;
		#4;
		scl_out = 1'b0;
		#20;
		scl_out = 1'b1;
	endtask
	task automatic bit_io(input logic v, output logic s);
		sda_low_out = !v;
		#(half / 2);
		scl_out = 1'b1;
		#(half / 2);
		s = sda_in;
		#(half / 2);
		scl_out = 1'b0;
		#(half / 2);
	endtask
	task automatic byte_io(input logic [7:0] w, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_io(w[i], r[i]);
		end
		bit_io(1'b1, k);
		k = !k;
	endtask
	task automatic xfer(input logic [6:0] adr, input logic rd, input logic [7:0] c,
		input logic [7:0] d, output logic [7:0] r, output logic [2:0] k);
		logic [7:0] x;
		sda_low_out = 1'b1;
		#(half / 2);
		scl_out = 1'b0;
		#(half / 2);
		byte_io({adr, rd}, x, k[2]);
		byte_io(c, x, k[1]);
		byte_io(rd ? 8'hFF : d, r, k[0]);
		sda_low_out = 1'b1;
		#(half / 2);
		scl_out = 1'b1;
		#(half / 2);
		sda_low_out = 1'b0;
		#half;
	endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the hot plug register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import hpsm_pkg::*;
	// ****
	// Bench
	// ****
	logic         clk_in;
	logic         srst_in;
	logic         scl;
	logic         host_low;
	wire logic    sda;
	logic         sda_o;
	logic         sda_oe_n;
	logic [2:0]   asel = 3'h5;
	logic [1:0]   aux_pin = 2'h0;
	logic [1:0]   main_pin = 2'h0;
	logic [1:0]   flt_pin = 2'h3;
	hpsm_slot_t   sa = '0;
	hpsm_slot_t   sb = '0;
	hpsm_common_t cm = '{gpi: 4'h9, default: 1'b0};
	logic [1:0]   aux_sup;
	logic [1:0]   main_sup;
	logic [1:0]   inhib;
	logic         bus_mode;
	logic         irq_n;
	logic [7:0]   func;
	int           mismatches = 0;
	int           checks_done = 0;
	int           cycles = 0;
	// Pull-up wins unless someone pulls low
	assign sda = !host_low && (sda_oe_n || sda_o);
	hpsm_regs_top dut (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .address_select_pins_in(asel),
		.aux_enable_pin_in(aux_pin), .main_on_pin_in(main_pin), .slot_fault_pin_in(flt_pin),
		.slot_a_in(sa), .slot_b_in(sb), .common_in(cm), .aux_supply_out(aux_sup),
		.main_supply_out(main_sup), .force_pin_inhibit_out(inhib), .bus_mode_out(bus_mode),
		.irq_n_out(irq_n), .func_reg_out(func));
	hpsm_host_model host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = !clk_in;
	end
	task automatic conclude;
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask
	task automatic settle;
		repeat (8) @(negedge clk_in);
	endtask
	task automatic rd(input logic [7:0] c, input logic [7:0] e, input logic v);
		logic [7:0] r;
		logic [2:0] k;
		host.xfer({4'h8, asel}, 1'b1, c, 8'h00, r, k);
		chk("read ack", 8'h06, 8'(k));
		if (v) chk($sformatf("reg %h", c), e, r);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		logic [2:0] k;
		host.xfer({4'h8, asel}, 1'b0, c, d, r, k);
		chk("write ack", 8'h07, 8'(k));
	endtask
	task automatic do_reset;
		srst_in = 1'b1;
		fork
			host.pulse();
		join_none
		repeat (6) @(negedge clk_in);
		srst_in = 1'b0;
		repeat (4) @(negedge clk_in);
	endtask
	task automatic t_defaults;
		chk("func", 8'h0D, func);
		chk("irq", 8'h01, 8'(irq_n));
		for (int i = 2; i < 6; i++) begin
			rd(8'(i), 8'h00, 1'b1);
		end
		rd(8'h06, 8'h90, 1'b1);
		rd(8'h07, 8'h0D, 1'b1);
	endtask
	task automatic t_direct;
		aux_pin = 2'h1;
		main_pin = 2'h2;
		flt_pin = 2'h2;
		settle();
		chk("aux", 8'h01, 8'(aux_sup));
		chk("main", 8'h02, 8'(main_sup));
		rd(8'h04, 8'hA0, 1'b1);
		rd(8'h05, 8'h40, 1'b1);
	endtask
	task automatic t_func;
		wr(8'h07, 8'hFF);
		settle();
		chk("func", 8'hCD, func);
		chk("mode", 8'h00, 8'(bus_mode));
	endtask
	task automatic t_refuse;
		logic [7:0] r;
		logic [2:0] k;
		host.xfer(7'h44, 1'b0, 8'h02, 8'h07, r, k);
		chk("foreign ack", 8'h00, 8'(k));
		for (int i = 0; i < 2; i++) begin
			host.xfer(7'h45, 1'b0, 8'(i), 8'h07, r, k);
			chk("unassigned ack", 8'h04, 8'(k));
		end
		settle();
		chk("mode", 8'h00, 8'(bus_mode));
	endtask
	task automatic t_bus;
		settle();
		aux_pin = 2'h0;
		main_pin = 2'h0;
		wr(8'h02, 8'hFF);
		settle();
		chk("mode", 8'h01, 8'(bus_mode));
		chk("supplies", 8'h05, {4'h0, aux_sup, main_sup});
		chk("inhib", 8'h01, 8'(inhib));
		rd(8'h02, 8'h07, 1'b1);
		rd(8'h04, 8'h60, 1'b1);
	endtask
	task automatic t_echo;
		wr(8'h02, 8'h04);
		host.half = 400;
		settle();
		sa = '{aux_fault: 1'b1, main3_fault: 1'b1, main12_fault: 1'b1, default: 1'b0};
		cm.ot_fault = 1'b1;
		settle();
		sa = '{main3_fault: 1'b1, default: 1'b0};
		cm.ot_fault = 1'b0;
		settle();
		chk("irq", 8'h00, 8'(irq_n));
		rd(8'h04, 8'h15, 1'b1);
		rd(8'h06, 8'h92, 1'b1);
		host.half = 80;
		wr(8'h04, 8'h15);
		wr(8'h06, 8'h02);
		rd(8'h04, 8'h00, 1'b0);
		rd(8'h06, 8'h00, 1'b0);
		rd(8'h04, 8'h01, 1'b1);
		rd(8'h06, 8'h90, 1'b1);
		wr(8'h06, 8'h08);
		settle();
		chk("irq", 8'h01, 8'(irq_n));
		rd(8'h06, 8'h98, 1'b1);
	endtask
	task automatic t_reset2;
		settle();
		sa = '0;
		aux_pin = 2'h2;
		do_reset();
		settle();
		chk("mode", 8'h00, 8'(bus_mode));
		chk("aux", 8'h02, 8'(aux_sup));
		rd(8'h02, 8'h00, 1'b1);
	endtask
	initial begin
		do_reset();
		t_defaults();
		t_direct();
		t_func();
		t_refuse();
		t_bus();
		t_echo();
		t_reset2();
		conclude();
	end
endmodule
`default_nettype wire
